// ### hw/mbcc_consts.svh
// offsets, keys, field positions, reset values and timing counts of the
// connection control block; assumes a 25 MHz clock and 16-bit registers
`ifndef MBCC_CONSTS_SVH
`define MBCC_CONSTS_SVH

`define MBCC_CLK_PERIOD_NS  40
`define MBCC_MS_NS          1000000
`define MBCC_MS_CYCLES      (`MBCC_MS_NS / `MBCC_CLK_PERIOD_NS)
`define MBCC_SEC_MS         1000
`define MBCC_KEY_WINDOW_S   30
`define MBCC_FLASH_HALF_MS  500

`define MBCC_ADDR_WDT       16'h1120
`define MBCC_ADDR_MODE      16'h1130
`define MBCC_ADDR_TIMEOUT   16'h1131
`define MBCC_ADDR_PARM_LAST 16'h113B
`define MBCC_ADDR_RKEY1     16'h113C
`define MBCC_ADDR_RKEY2     16'h113D
`define MBCC_ADDR_SKEY1     16'h113E
`define MBCC_ADDR_SKEY2     16'h113F

`define MBCC_KEY_RESTORE1   16'h6C6F
`define MBCC_KEY_RESTORE2   16'h6164
`define MBCC_KEY_SAVE1      16'h7361
`define MBCC_KEY_SAVE2      16'h7665

`define MBCC_MODE_SINGLE    0
`define MBCC_MODE_GRANT     1

`define MBCC_WDT_RST        16'h0000
`define MBCC_MODE_RST       2'h0
`define MBCC_TIMEOUT_RST    16'h0000
`define MBCC_KEY_RST        16'h0000

`define MBCC_EXC_NONE       8'h00
`define MBCC_EXC_FUNC       8'h01
`define MBCC_EXC_ADDR       8'h02

`define MBCC_CONN_W         4
`define MBCC_OUT_W          16
`define MBCC_CYC_W          24
`define MBCC_WIN_W          5

`endif

// ### hw/mbcc_pkg.sv
// types of the connection control block
// assumes mbcc_consts.svh on the include path
`include "mbcc_consts.svh"

package mbcc_pkg;

  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic [`MBCC_CONN_W-1:0] conn;
    logic [15:0]             addr;
    logic [15:0]             data;
  } mbcc_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  exc;
    logic [15:0] data;
  } mbcc_rsp_t;

  typedef struct packed {
    logic [15:0] wdt_ms;
    logic [1:0]  mode;
    logic [15:0] timeout_s;
  } mbcc_parm_t;

  typedef struct packed {
    logic        open;
    logic        auth;
    logic        drop;
    logic [15:0] idle_s;
  } mbcc_slot_t;

  typedef struct packed {
    logic [`MBCC_CYC_W-1:0] cyc;
    logic [9:0]             ms;
    logic [9:0]             flash_ms;
    logic                   flash;
    mbcc_parm_t             parm;
    logic [15:0]            rkey1;
    logic [15:0]            rkey2;
    logic [15:0]            skey1;
    logic [15:0]            skey2;
    logic                   r_arm;
    logic [`MBCC_WIN_W-1:0] r_sec;
    logic                   s_arm;
    logic [`MBCC_WIN_W-1:0] s_sec;
    logic                   nv_save;
    mbcc_parm_t             nv_data;
    logic [15:0]            idle_ms;
    logic                   tripped;
    logic                   tmo_seen;
    logic                   led_green;
    logic                   led_red;
    logic [`MBCC_OUT_W-1:0] out_q;
    mbcc_rsp_t              rsp;
  } mbcc_state_t;

endpackage : mbcc_pkg

// ### hw/mbcc_conn_slot.sv
// one connection slot: open state, write authorization, inactivity timer
// assumes one-cycle open/close/activity pulses and a one-cycle second tick
`timescale 1ns/1ps
`include "mbcc_consts.svh"

module mbcc_conn_slot (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        open_evt,
  input  wire logic        close_evt,
  input  wire logic        grant,
  input  wire logic        activity,
  input  wire logic        sec_tick,
  input  wire logic [15:0] timeout_s,
  output logic             is_open,
  output logic             auth,
  output logic             drop
);

  mbcc_pkg::mbcc_slot_t s_r;
  mbcc_pkg::mbcc_slot_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.drop = 1'b0;
    if (close_evt || s_r.drop) begin
      s_nxt.open   = 1'b0;
      s_nxt.auth   = 1'b0;
      s_nxt.idle_s = 16'h0000;
    end else if (open_evt) begin
      s_nxt.open   = 1'b1;
      s_nxt.auth   = grant;
      s_nxt.idle_s = 16'h0000;
    end else if (s_r.open) begin
      if (grant) begin
        s_nxt.auth = 1'b1;
      end
      if (activity) begin
        s_nxt.idle_s = 16'h0000;
      end else if (sec_tick && (timeout_s != 16'h0000)) begin
        if (s_r.idle_s != 16'hFFFF) begin
          s_nxt.idle_s = s_r.idle_s + 16'h0001;
        end
        if ((s_r.idle_s + 17'h00001) >= {1'b0, timeout_s}) begin
          s_nxt.drop = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign is_open = s_r.open;
  assign auth    = s_r.auth;
  assign drop    = s_r.drop;

endmodule : mbcc_conn_slot

// ### hw/mbcc_top.sv
// modbus connection control: write permission, inactivity disconnect,
// restore/save key sequences and communication watchdog with bus led
// assumes the modbus stack splits multi-register requests into word
// requests in address order, one per cycle at most, on this clock
`timescale 1ns/1ps
`include "mbcc_consts.svh"

// Operation
// - single-writer clear: every open connection gets write permission.
// - single-writer set: one holder at most, kept until it disconnects.
// - after the holder leaves, next writing connection gets permission.
// - grant-at-connect clear: first write asks permission, refusal answers exception 0x01.
// - granted on demand: write executes, permission lasts until connection closes.
// - grant-at-connect set: permission given when the connection opens.
// - both bits set: first opened connection holds it, later ones are refused.
// - connection idle for the timeout register's time is disconnected.
// - a connection timeout flashes the bus led green.
// - restore returns watchdog time and 0x1130..0x113B to defaults.
// - restore runs only if 0x6164 reaches the second within 30 s.
// - both key words may come in one multi-register write.
// - restore changes working values only, nothing is stored.
// - save stores watchdog time and 0x1130..0x113B to non-volatile memory.
// - save runs only if 0x7665 reaches the second within 30 s.
// - watchdog time zero: outputs hold their values on failure.
// - nonzero watchdog time: outputs go to zero after it expires.
// - substitute output values are never applied.
// - bus led steady red while the watchdog is tripped.
// - timeout in seconds, zero disables the inactivity disconnect.
module mbcc_top #(
  parameter int                     N_CONN    = 4,
  parameter logic [`MBCC_CYC_W-1:0] MS_CYCLES = `MBCC_CYC_W'(`MBCC_MS_CYCLES)
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire mbcc_pkg::mbcc_req_t    req,
  output mbcc_pkg::mbcc_rsp_t         rsp,
  input  wire logic [N_CONN-1:0]      conn_open,
  input  wire logic [N_CONN-1:0]      conn_close,
  output logic [N_CONN-1:0]           conn_disconnect,
  output logic [N_CONN-1:0]           conn_auth,
  input  wire logic [`MBCC_OUT_W-1:0] out_data,
  output logic [`MBCC_OUT_W-1:0]      out_q,
  output logic                        nv_save,
  output mbcc_pkg::mbcc_parm_t        nv_data,
  output logic                        wdt_tripped,
  output logic                        led_green,
  output logic                        led_red
);

  mbcc_pkg::mbcc_state_t s_r;
  mbcc_pkg::mbcc_state_t s_nxt;

  logic [N_CONN-1:0] open_vec;
  logic [N_CONN-1:0] auth_vec;
  logic [N_CONN-1:0] drop_vec;
  logic [N_CONN-1:0] grant_vec;
  logic [N_CONN-1:0] act_vec;
  logic              ms_tick;
  logic              sec_tick;
  logic              single;
  logic              at_connect;
  logic              holder;
  logic              taken;
  logic              own_auth;
  logic              conn_ok;
  logic              allowed;

  assign single     = s_r.parm.mode[`MBCC_MODE_SINGLE];
  assign at_connect = s_r.parm.mode[`MBCC_MODE_GRANT];
  assign holder     = |auth_vec;
  assign ms_tick    = (s_r.cyc == (MS_CYCLES - `MBCC_CYC_W'(1)));
  assign sec_tick   = ms_tick && (s_r.ms == 10'(`MBCC_SEC_MS - 1));

  // permission arbitration and activity per connection
  always_comb begin
    grant_vec = '0;
    act_vec   = '0;
    own_auth  = 1'b0;
    conn_ok   = 1'b0;
    allowed   = 1'b0;
    taken     = holder;
    for (int i = 0; i < N_CONN; i++) begin
      if (req.valid && (req.conn == `MBCC_CONN_W'(i)) && open_vec[i]) begin
        conn_ok    = 1'b1;
        own_auth   = auth_vec[i];
        act_vec[i] = 1'b1;
      end
    end
    allowed = conn_ok && (own_auth || !single || !holder);
    for (int i = 0; i < N_CONN; i++) begin
      if (req.valid && req.write && allowed && !own_auth
          && (req.conn == `MBCC_CONN_W'(i))) begin
        grant_vec[i] = 1'b1;
        taken        = 1'b1;
      end
    end
    for (int i = 0; i < N_CONN; i++) begin
      if (conn_open[i] && !open_vec[i] && at_connect) begin
        if (!single) begin
          grant_vec[i] = 1'b1;
        end else if (!taken) begin
          grant_vec[i] = 1'b1;
          taken        = 1'b1;
        end
      end
    end
  end

  always_comb begin
    s_nxt         = s_r;
    s_nxt.rsp     = '0;
    s_nxt.nv_save = 1'b0;

    // millisecond and second time base
    if (ms_tick) begin
      s_nxt.cyc = '0;
      s_nxt.ms  = sec_tick ? 10'h000 : s_r.ms + 10'h001;
    end else begin
      s_nxt.cyc = s_r.cyc + `MBCC_CYC_W'(1);
    end

    // key windows expire after the allowed seconds
    if (sec_tick && s_r.r_arm) begin
      s_nxt.r_sec = s_r.r_sec + `MBCC_WIN_W'(1);
      if (s_nxt.r_sec >= `MBCC_WIN_W'(`MBCC_KEY_WINDOW_S)) begin
        s_nxt.r_arm = 1'b0;
      end
    end
    if (sec_tick && s_r.s_arm) begin
      s_nxt.s_sec = s_r.s_sec + `MBCC_WIN_W'(1);
      if (s_nxt.s_sec >= `MBCC_WIN_W'(`MBCC_KEY_WINDOW_S)) begin
        s_nxt.s_arm = 1'b0;
      end
    end

    // communication watchdog
    if (ms_tick && (s_r.idle_ms != 16'hFFFF)) begin
      s_nxt.idle_ms = s_r.idle_ms + 16'h0001;
    end
    if (s_r.parm.wdt_ms == 16'h0000) begin
      s_nxt.tripped = 1'b0;
    end else if (s_nxt.idle_ms >= s_r.parm.wdt_ms) begin
      s_nxt.tripped = 1'b1;
    end

    // register requests
    if (req.valid) begin
      s_nxt.rsp.valid = 1'b1;
      if (conn_ok) begin
        s_nxt.idle_ms = 16'h0000;
        s_nxt.tripped = 1'b0;
      end
      if (req.write) begin
        if (!allowed) begin
          s_nxt.rsp.exc = `MBCC_EXC_FUNC;
        end else begin
          case (req.addr)
            `MBCC_ADDR_WDT: begin
              s_nxt.parm.wdt_ms = req.data;
            end
            `MBCC_ADDR_MODE: begin
              s_nxt.parm.mode = req.data[1:0];
            end
            `MBCC_ADDR_TIMEOUT: begin
              s_nxt.parm.timeout_s = req.data;
            end
            `MBCC_ADDR_RKEY1: begin
              s_nxt.rkey1 = req.data;
              s_nxt.r_arm = (req.data == `MBCC_KEY_RESTORE1);
              s_nxt.r_sec = '0;
            end
            `MBCC_ADDR_RKEY2: begin
              s_nxt.rkey2 = req.data;
              s_nxt.r_arm = 1'b0;
              if (s_nxt.r_arm == 1'b0 && s_r.r_arm
                  && (s_r.r_sec < `MBCC_WIN_W'(`MBCC_KEY_WINDOW_S))
                  && (req.data == `MBCC_KEY_RESTORE2)) begin
                s_nxt.parm.wdt_ms    = `MBCC_WDT_RST;
                s_nxt.parm.mode      = `MBCC_MODE_RST;
                s_nxt.parm.timeout_s = `MBCC_TIMEOUT_RST;
              end
            end
            `MBCC_ADDR_SKEY1: begin
              s_nxt.skey1 = req.data;
              s_nxt.s_arm = (req.data == `MBCC_KEY_SAVE1);
              s_nxt.s_sec = '0;
            end
            `MBCC_ADDR_SKEY2: begin
              s_nxt.skey2 = req.data;
              s_nxt.s_arm = 1'b0;
              if (s_r.s_arm && (s_r.s_sec < `MBCC_WIN_W'(`MBCC_KEY_WINDOW_S))
                  && (req.data == `MBCC_KEY_SAVE2)) begin
                s_nxt.nv_save = 1'b1;
                s_nxt.nv_data = s_r.parm;
              end
            end
            default: begin
              if ((req.addr <= `MBCC_ADDR_PARM_LAST)
                  && (req.addr > `MBCC_ADDR_TIMEOUT)) begin
                s_nxt.rsp.exc = `MBCC_EXC_NONE;
              end else begin
                s_nxt.rsp.exc = `MBCC_EXC_ADDR;
              end
            end
          endcase
        end
      end else begin
        case (req.addr)
          `MBCC_ADDR_WDT: begin
            s_nxt.rsp.data = s_r.parm.wdt_ms;
          end
          `MBCC_ADDR_MODE: begin
            s_nxt.rsp.data = {14'h0000, s_r.parm.mode};
          end
          `MBCC_ADDR_TIMEOUT: begin
            s_nxt.rsp.data = s_r.parm.timeout_s;
          end
          `MBCC_ADDR_RKEY1: begin
            s_nxt.rsp.data = s_r.rkey1;
          end
          `MBCC_ADDR_RKEY2: begin
            s_nxt.rsp.data = s_r.rkey2;
          end
          `MBCC_ADDR_SKEY1: begin
            s_nxt.rsp.data = s_r.skey1;
          end
          `MBCC_ADDR_SKEY2: begin
            s_nxt.rsp.data = s_r.skey2;
          end
          default: begin
            if ((req.addr <= `MBCC_ADDR_PARM_LAST)
                && (req.addr > `MBCC_ADDR_TIMEOUT)) begin
              s_nxt.rsp.data = 16'h0000;
            end else begin
              s_nxt.rsp.exc = `MBCC_EXC_ADDR;
            end
          end
        endcase
      end
    end

    // outputs: zero when tripped, otherwise follow; no substitute values
    s_nxt.out_q = s_nxt.tripped ? '0 : out_data;

    // bus led: red over green flash
    if (|drop_vec) begin
      s_nxt.tmo_seen = 1'b1;
    end else if (|(conn_open & ~open_vec)) begin
      s_nxt.tmo_seen = 1'b0;
    end
    if (ms_tick) begin
      if (s_r.flash_ms == 10'(`MBCC_FLASH_HALF_MS - 1)) begin
        s_nxt.flash_ms = 10'h000;
        s_nxt.flash    = !s_r.flash;
      end else begin
        s_nxt.flash_ms = s_r.flash_ms + 10'h001;
      end
    end
    s_nxt.led_red   = s_nxt.tripped;
    s_nxt.led_green = !s_nxt.tripped && s_nxt.tmo_seen && s_r.flash;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r                <= '0;
      s_r.parm.wdt_ms    <= `MBCC_WDT_RST;
      s_r.parm.mode      <= `MBCC_MODE_RST;
      s_r.parm.timeout_s <= `MBCC_TIMEOUT_RST;
      s_r.rkey1          <= `MBCC_KEY_RST;
      s_r.rkey2          <= `MBCC_KEY_RST;
      s_r.skey1          <= `MBCC_KEY_RST;
      s_r.skey2          <= `MBCC_KEY_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  for (genvar g = 0; g < N_CONN; g++) begin : g_slot
    mbcc_conn_slot u_slot (
      .clock     (clock),
      .rst       (rst),
      .open_evt  (conn_open[g]),
      .close_evt (conn_close[g]),
      .grant     (grant_vec[g]),
      .activity  (act_vec[g]),
      .sec_tick  (sec_tick),
      .timeout_s (s_r.parm.timeout_s),
      .is_open   (open_vec[g]),
      .auth      (auth_vec[g]),
      .drop      (drop_vec[g])
    );
  end

  assign rsp             = s_r.rsp;
  assign conn_disconnect = drop_vec;
  assign conn_auth       = auth_vec;
  assign out_q           = s_r.out_q;
  assign nv_save         = s_r.nv_save;
  assign nv_data         = s_r.nv_data;
  assign wdt_tripped     = s_r.tripped;
  assign led_green       = s_r.led_green;
  assign led_red         = s_r.led_red;

endmodule : mbcc_top

// ### bench/mbcc_chk.sv
// assertions on the ports of the connection control block
// assumes mbcc_pkg and mbcc_consts.svh are compiled first
`timescale 1ns/1ps
`include "mbcc_consts.svh"

module mbcc_chk #(
  parameter int                     N_CONN    = 4,
  parameter logic [`MBCC_CYC_W-1:0] MS_CYCLES = 1
) (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire mbcc_pkg::mbcc_req_t    req,
  input wire mbcc_pkg::mbcc_rsp_t    rsp,
  input wire logic [N_CONN-1:0]      conn_open,
  input wire logic [N_CONN-1:0]      conn_close,
  input wire logic [N_CONN-1:0]      conn_disconnect,
  input wire logic [N_CONN-1:0]      conn_auth,
  input wire logic [`MBCC_OUT_W-1:0] out_data,
  input wire logic [`MBCC_OUT_W-1:0] out_q,
  input wire logic                   nv_save,
  input wire mbcc_pkg::mbcc_parm_t   nv_data,
  input wire logic                   wdt_tripped,
  input wire logic                   led_green,
  input wire logic                   led_red
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_rsp_next_cycle: assert property (req.valid |=> rsp.valid)
    else $error("request left unanswered");
  a_unmapped_addr: assert property (req.valid && req.addr != 16'h1120
      && !(req.addr inside {[16'h1130:16'h113F]}) |=> rsp.exc == 8'h02)
    else $error("unmapped address not refused");
  a_write_data_zero: assert property (req.valid && req.write |=> rsp.data == 16'h0000)
    else $error("write answer carries data");
  a_red_means_trip: assert property (led_red == wdt_tripped)
    else $error("red led differs from trip");
  a_trip_zero_out: assert property (wdt_tripped |-> out_q == 16'h0000)
    else $error("outputs not cleared on trip");
  a_out_follows: assert property (!wdt_tripped && !$past(rst) |-> out_q == $past(out_data))
    else $error("outputs not held from stack");
  a_green_off_trip: assert property (wdt_tripped |-> !led_green)
    else $error("green led lit while tripped");
  a_disc_drops_auth: assert property (|conn_disconnect |=>
      ((conn_auth | conn_disconnect) & $past(conn_disconnect)) == '0)
    else $error("dropped connection keeps permission");
  a_save_on_key: assert property (nv_save |-> $past(req.valid && req.write
      && req.addr == 16'h113F && req.data == 16'h7665))
    else $error("save without second key");
endmodule : mbcc_chk

bind mbcc_top mbcc_chk #(.N_CONN(N_CONN), .MS_CYCLES(MS_CYCLES)) mbcc_chk_inst (
  .clock(clock), .rst(rst), .req(req), .rsp(rsp), .conn_open(conn_open),
  .conn_close(conn_close), .conn_disconnect(conn_disconnect), .conn_auth(conn_auth),
  .out_data(out_data), .out_q(out_q), .nv_save(nv_save), .nv_data(nv_data),
  .wdt_tripped(wdt_tripped), .led_green(led_green), .led_red(led_red));

// ### bench/mbcc_master.sv
// behavioural modbus master issuing word requests to the block
// assumes requests change on the falling edge, answers one edge after take
`timescale 1ns/1ps

module mbcc_master (
  input  wire mbcc_pkg::mbcc_rsp_t rsp,
  input  wire logic                clock,
  output mbcc_pkg::mbcc_req_t      req
);
  initial req = '0;

  // released bus shows inverted leftovers, never the old word
  task automatic release_bus();
    req.valid = 1'b0;
    req.addr  = ~req.addr;
    req.data  = ~req.data;
  endtask : release_bus

  // n words on consecutive cycles at ascending addresses
  task automatic send(input logic w, input logic [3:0] c, input logic [15:0] a,
                      input logic [15:0] d0, input logic [15:0] d1, input int n,
                      output mbcc_pkg::mbcc_rsp_t r0, output mbcc_pkg::mbcc_rsp_t r1);
    @(negedge clock);
    req = '{1'b1, w, c, a, d0};
    @(negedge clock);
    r0 = rsp;
    if (n == 2) req = '{1'b1, w, c, a + 16'h0001, d1};
    else release_bus();
    @(negedge clock);
    r1 = rsp;
    if (n == 2) release_bus();
    @(negedge clock);
  endtask : send
endmodule : mbcc_master

// ### bench/tb.sv
// self-checking bench of the connection control block
// assumes design, package, checker and master model compiled first
`timescale 1ns/1ps
`include "mbcc_consts.svh"

module tb;
  logic                 clock;
  logic                 rst;
  mbcc_pkg::mbcc_req_t  req;
  mbcc_pkg::mbcc_rsp_t  rsp;
  mbcc_pkg::mbcc_rsp_t  r0;
  mbcc_pkg::mbcc_rsp_t  r1;
  mbcc_pkg::mbcc_parm_t nv_data;
  mbcc_pkg::mbcc_parm_t nv_cap;
  logic [3:0]           conn_open;
  logic [3:0]           conn_close;
  logic [3:0]           conn_disconnect;
  logic [3:0]           conn_auth;
  logic [15:0]          out_data;
  logic [15:0]          out_q;
  logic                 nv_save;
  logic                 wdt_tripped;
  logic                 led_green;
  logic                 led_red;
  int                   n_fail;
  int                   samples_checked;
  int                   n_save;
  int                   n_disc;
  int                   n_green;

  mbcc_top #(.N_CONN(4), .MS_CYCLES(`MBCC_CYC_W'(2))) mbcc_top_inst (
    .clock(clock), .rst(rst), .req(req), .rsp(rsp), .conn_open(conn_open),
    .conn_close(conn_close), .conn_disconnect(conn_disconnect), .conn_auth(conn_auth),
    .out_data(out_data), .out_q(out_q), .nv_save(nv_save), .nv_data(nv_data),
    .wdt_tripped(wdt_tripped), .led_green(led_green), .led_red(led_red));

  mbcc_master mbcc_master_inst (.rsp(rsp), .clock(clock), .req(req));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(negedge clock) begin
    if (!rst) begin
      n_save += int'(nv_save);
      n_disc += int'(|conn_disconnect);
      n_green += int'(led_green);
      if (nv_save) nv_cap = nv_data;
    end
  end

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] c, input logic [15:0] a, input logic [15:0] d,
                    input logic [7:0] exc);
    mbcc_master_inst.send(1'b1, c, a, d, 16'h0000, 1, r0, r1);
    check(36'({r0.valid, r0.exc}), 36'({1'b1, exc}));
  endtask : wr

  task automatic rd(input logic [3:0] c, input logic [15:0] a, input logic [15:0] exp);
    mbcc_master_inst.send(1'b0, c, a, 16'h0000, 16'h0000, 1, r0, r1);
    check(36'({r0.valid, r0.exc, r0.data}), 36'({1'b1, 8'h00, exp}));
  endtask : rd

  task automatic pair(input logic [15:0] a, input logic [15:0] d0, input logic [15:0] d1);
    mbcc_master_inst.send(1'b1, 4'h0, a, d0, d1, 2, r0, r1);
    check(36'({r0.valid, r0.exc, r1.valid, r1.exc}), 36'({1'b1, 8'h00, 1'b1, 8'h00}));
  endtask : pair

  task automatic pulse(input logic [3:0] o, input logic [3:0] c);
    @(negedge clock);
    conn_open = o;
    conn_close = c;
    @(negedge clock);
    conn_open = 4'h0;
    conn_close = 4'h0;
    @(negedge clock);
  endtask : pulse

  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    conn_open = 4'h0;
    conn_close = 4'h0;
    out_data = 16'h5A5A;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    pulse(4'h3, 4'h0);
    rd(4'h0, 16'h1120, 16'h0000);
    rd(4'h0, 16'h1130, 16'h0000);
    rd(4'h0, 16'h1131, 16'h0000);
    wr(4'h0, 16'h1120, 16'h0009, 8'h00);
    wr(4'h1, 16'h1131, 16'h0005, 8'h00);
    check(36'(conn_auth), 36'(4'h3));
    wr(4'h1, 16'h1121, 16'h0001, 8'h02);
    wr(4'h1, 16'h1132, 16'h1234, 8'h00);
    rd(4'h1, 16'h1132, 16'h0000);
    wr(4'h0, 16'h1130, 16'h0001, 8'h00);
    pulse(4'h0, 4'h3);
    pulse(4'h3, 4'h0);
    check(36'(conn_auth), 36'(4'h0));
    wr(4'h1, 16'h1131, 16'h0005, 8'h00);
    wr(4'h0, 16'h1120, 16'h0001, 8'h01);
    rd(4'h0, 16'h1120, 16'h0009);
    pulse(4'h0, 4'h2);
    wr(4'h0, 16'h1120, 16'h0009, 8'h00);
    check(36'(conn_auth), 36'(4'h1));
    wr(4'h0, 16'h1130, 16'hFFFF, 8'h00);
    rd(4'h0, 16'h1130, 16'h0003);
    pulse(4'h0, 4'h1);
    pulse(4'h1, 4'h0);
    pulse(4'h2, 4'h0);
    check(36'(conn_auth), 36'(4'h1));
    wr(4'h1, 16'h1120, 16'h0001, 8'h01);
    wr(4'h0, 16'h1130, 16'h0002, 8'h00);
    pulse(4'h4, 4'h0);
    check(36'(conn_auth[2]), 36'(1'b1));
    wr(4'h0, 16'h113C, 16'h6C6F, 8'h00);
    wr(4'h0, 16'h113D, 16'h1234, 8'h00);
    wr(4'h0, 16'h113D, 16'h6164, 8'h00);
    rd(4'h0, 16'h1120, 16'h0009);
    pair(16'h113C, 16'h6C6F, 16'h6164);
    rd(4'h0, 16'h1120, 16'h0000);
    rd(4'h0, 16'h1130, 16'h0000);
    rd(4'h0, 16'h1131, 16'h0000);
    check(36'(n_save), 36'(0));
    out_data = 16'hA5A5;
    repeat (60) @(negedge clock);
    check(36'({wdt_tripped, out_q}), 36'({1'b0, 16'hA5A5}));
    wr(4'h0, 16'h1120, 16'h0003, 8'h00);
    pair(16'h113E, 16'h7361, 16'h7665);
    check(36'(n_save), 36'(1));
    check(36'(nv_cap), 36'({16'h0003, 2'h0, 16'h0000}));
    repeat (12) @(negedge clock);
    check(36'({wdt_tripped, led_red, out_q}), 36'({2'b11, 16'h0000}));
    repeat (2100) @(negedge clock);
    check(36'(n_disc), 36'(0));
    wr(4'h0, 16'h1120, 16'h0000, 8'h00);
    check(36'(wdt_tripped), 36'(1'b0));
    wr(4'h0, 16'h1131, 16'h0001, 8'h00);
    for (int i = 0; i < 2100 && n_disc == 0; i++) @(negedge clock);
    repeat (2) @(posedge clock);
    n_green = 0;
    repeat (4000) @(posedge clock);
    check(36'({n_disc != 0, conn_auth}), 36'({1'b1, 4'h0}));
    check(36'(n_green), 36'(2000));
    complete_run();
  end
endmodule : tb
